// file: core/omlsc_ctrl.sv
// Top of the optical module low-speed control block.
`include "omlsc_params.svh"
module omlsc_ctrl
    import omlsc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host control pins.
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    input wire logic transmit_disable,
    // Serial bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Alert and presence.
    output logic alert_n_out,
    output logic alert_n_oe,
    output logic presence_detect_n,
    // Optical side.
    input wire omlsc_pkg::omlsc_lanes_t rx_power,
    output logic [3:0] tx_lane_enable,
    output logic receive_signal_loss_alarm,
    output logic high_power_enable,
    output logic data_not_ready
);
    import omlsc_pkg::*;

    omlsc_pins_t pins_async;
    omlsc_pins_t pins;
    logic soft_reset;
    logic scl_prev;
    logic sda_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    omlsc_tw_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] txreg;
    logic [7:0] pointer;
    logic first_byte;
    logic host_ack;
    logic wr_strobe;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_strobe;
    logic [7:0] rd_addr;
    logic [7:0] rd_next;
    logic [3:0] sw_tx_disable;
    logic [15:0] los_threshold;
    logic [3:0] lane_low;
    logic [3:0] los_flags;
    logic reset_done;
    logic [7:0] init_count;
    logic init_end;

    //==========================================================
    // Pin synchronisation and reset qualification.
    assign pins_async = '{scl: scl_in, sda: sda_in, select_n: module_select_n,
                          reset_n: module_reset_n, low_power: low_power_select,
                          tx_disable: transmit_disable};

    omlsc_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pins_async(pins_async),
        .pins_sync(pins)
    );

    omlsc_rst_qual #(
        .MIN_CYCLES(`OMLSC_RESET_MIN_CYCLES)
    ) u_rst_qual (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .level_n(pins.reset_n),
        .hold(soft_reset)
    );

    //==========================================================
    // Read decode of the memory map.
    function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                             input logic dnr,
                                             input logic done,
                                             input logic [3:0] flags,
                                             input omlsc_lanes_t pwr,
                                             input logic [3:0] dis,
                                             input logic [15:0] thr);
        logic [7:0] value;
        value = 8'h00;
        if (addr == `OMLSC_ADDR_STATUS) begin
            value[`OMLSC_BIT_NOT_READY] = dnr;
            value[`OMLSC_BIT_RESET_DONE] = done;
            value[`OMLSC_BIT_LOS_ANY] = |flags;
        end else if (addr == `OMLSC_ADDR_LOS_FLAGS) begin
            value = {4'h0, flags};
        end else if (addr >= `OMLSC_ADDR_RX_POWER && addr < `OMLSC_ADDR_TX_DISABLE) begin
            value = addr[0] ? pwr[3'(addr[3:1] - 3'h1)][7:0]
                            : pwr[3'(addr[3:1] - 3'h1)][15:8];
        end else if (addr == `OMLSC_ADDR_TX_DISABLE) begin
            value = {4'h0, dis};
        end else if (addr == `OMLSC_ADDR_LOS_THR_HI) begin
            value = thr[15:8];
        end else if (addr == `OMLSC_ADDR_LOS_THR_LO) begin
            value = thr[7:0];
        end
        return value;
    endfunction : read_byte

    assign rd_next = read_byte(pointer, data_not_ready, reset_done, los_flags, rx_power,
                               sw_tx_disable, los_threshold);

    //==========================================================
    // Serial bus edge and condition detection.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= pins.scl;
            sda_prev <= pins.sda;
        end
    end

    assign scl_rise = pins.scl && !scl_prev;
    assign scl_fall = !pins.scl && scl_prev;
    assign start_seen = pins.scl && scl_prev && sda_prev && !pins.sda;
    assign stop_seen = pins.scl && scl_prev && !sda_prev && pins.sda;

    //==========================================================
    // Serial bus slave.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TW_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            pointer <= 8'h00;
            first_byte <= 1'b0;
            host_ack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            wr_strobe <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            rd_strobe <= 1'b0;
            rd_addr <= 8'h00;
        end else begin
            wr_strobe <= 1'b0;
            rd_strobe <= 1'b0;
            if (pins.select_n || soft_reset || stop_seen) begin
                state <= TW_IDLE;
                sda_oe <= 1'b0;
            end else if (start_seen) begin
                state <= TW_ADDR;
                bit_cnt <= 4'h0;
                first_byte <= 1'b1;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                unique case (state)
                    TW_ADDR, TW_WRITE: begin
                        shreg <= {shreg[6:0], pins.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    TW_READ_ACK: begin
                        host_ack <= !pins.sda;
                    end
                    TW_IDLE, TW_ADDR_ACK, TW_WRITE_ACK, TW_READ: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state)
                    TW_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            if (shreg[7:1] == `OMLSC_DEV_ADDR) begin
                                state <= TW_ADDR_ACK;
                                sda_oe <= 1'b1;
                            end else begin
                                state <= TW_IDLE;
                            end
                        end
                    end
                    TW_ADDR_ACK: begin
                        if (shreg[0]) begin
                            state <= TW_READ;
                            txreg <= rd_next << 1;
                            sda_oe <= !rd_next[7];
                            rd_strobe <= 1'b1;
                            rd_addr <= pointer;
                            pointer <= pointer + 8'h01;
                            bit_cnt <= 4'h1;
                        end else begin
                            state <= TW_WRITE;
                            sda_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                        end
                    end
                    TW_WRITE: begin
                        if (bit_cnt == 4'h8) begin
                            state <= TW_WRITE_ACK;
                            sda_oe <= 1'b1;
                            first_byte <= 1'b0;
                            if (first_byte) begin
                                pointer <= shreg;
                            end else begin
                                wr_strobe <= 1'b1;
                                wr_addr <= pointer;
                                wr_data <= shreg;
                                pointer <= pointer + 8'h01;
                            end
                        end
                    end
                    TW_WRITE_ACK: begin
                        state <= TW_WRITE;
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                    end
                    TW_READ: begin
                        if (bit_cnt == 4'h8) begin
                            state <= TW_READ_ACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= !txreg[7];
                            txreg <= txreg << 1;
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    TW_READ_ACK: begin
                        if (host_ack) begin
                            state <= TW_READ;
                            txreg <= rd_next << 1;
                            sda_oe <= !rd_next[7];
                            rd_strobe <= 1'b1;
                            rd_addr <= pointer;
                            pointer <= pointer + 8'h01;
                            bit_cnt <= 4'h1;
                        end else begin
                            state <= TW_IDLE;
                        end
                    end
                    TW_IDLE: begin
                    end
                endcase
            end
        end
    end

    //==========================================================
    // Writable settings, restored to defaults by a qualified reset.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_tx_disable <= `OMLSC_TRANSMIT_DISABLE_RESET;
            los_threshold <= `OMLSC_LOS_THR_RESET;
        end else if (soft_reset) begin
            sw_tx_disable <= `OMLSC_TRANSMIT_DISABLE_RESET;
            los_threshold <= `OMLSC_LOS_THR_RESET;
        end else if (wr_strobe) begin
            if (wr_addr == `OMLSC_ADDR_TX_DISABLE) begin
                sw_tx_disable <= wr_data[3:0];
            end
            if (wr_addr == `OMLSC_ADDR_LOS_THR_HI) begin
                los_threshold[15:8] <= wr_data;
            end
            if (wr_addr == `OMLSC_ADDR_LOS_THR_LO) begin
                los_threshold[7:0] <= wr_data;
            end
        end
    end

    //==========================================================
    // Initialisation after power-up or a qualified reset.
    assign init_end = data_not_ready && (init_count == 8'(`OMLSC_INIT_CYCLES));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_count <= 8'h00;
            data_not_ready <= 1'b1;
        end else if (soft_reset) begin
            init_count <= 8'h00;
            data_not_ready <= 1'b1;
        end else if (init_end) begin
            data_not_ready <= 1'b0;
        end else if (data_not_ready) begin
            init_count <= init_count + 8'h01;
        end
    end

    //==========================================================
    // Sticky alert causes; a new event wins over the read that clears it.
    assign lane_low[0] = rx_power[0] < los_threshold;
    assign lane_low[1] = rx_power[1] < los_threshold;
    assign lane_low[2] = rx_power[2] < los_threshold;
    assign lane_low[3] = rx_power[3] < los_threshold;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_done <= 1'b0;
            los_flags <= 4'h0;
        end else if (soft_reset) begin
            reset_done <= 1'b0;
            los_flags <= 4'h0;
        end else begin
            if (init_end) begin
                reset_done <= 1'b1;
            end else if (rd_strobe && rd_addr == `OMLSC_ADDR_STATUS) begin
                reset_done <= 1'b0;
            end
            if (rd_strobe && rd_addr == `OMLSC_ADDR_LOS_FLAGS) begin
                los_flags <= lane_low;
            end else begin
                los_flags <= los_flags | lane_low;
            end
        end
    end

    //==========================================================
    // Pin outputs.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_out <= 1'b0;
            alert_n_oe <= 1'b0;
            presence_detect_n <= 1'b0;
            receive_signal_loss_alarm <= 1'b0;
            tx_lane_enable <= 4'h0;
            high_power_enable <= 1'b0;
        end else begin
            alert_n_out <= 1'b0;
            alert_n_oe <= !data_not_ready && (reset_done || |los_flags);
            presence_detect_n <= 1'b0;
            receive_signal_loss_alarm <= |lane_low;
            tx_lane_enable <= soft_reset ? 4'h0
                : ~(sw_tx_disable | {4{pins.tx_disable}});
            high_power_enable <= !pins.low_power && !soft_reset;
        end
    end

endmodule : omlsc_ctrl

// file: core/omlsc_params.svh
// Constants of the optical module low-speed control block.
//==========================================================
`ifndef OMLSC_PARAMS_SVH
`define OMLSC_PARAMS_SVH

//==========================================================
// Timing.
`define OMLSC_CLK_PERIOD_NS 20
`define OMLSC_RESET_MIN_NS 10000
`define OMLSC_RESET_MIN_CYCLES \
    ((`OMLSC_RESET_MIN_NS + `OMLSC_CLK_PERIOD_NS - 1) / `OMLSC_CLK_PERIOD_NS)
`define OMLSC_INIT_NS 320
`define OMLSC_INIT_CYCLES \
    ((`OMLSC_INIT_NS + `OMLSC_CLK_PERIOD_NS - 1) / `OMLSC_CLK_PERIOD_NS)

//==========================================================
// Serial bus and memory map.
`define OMLSC_DEV_ADDR 7'h50
`define OMLSC_ADDR_STATUS 8'h00
`define OMLSC_ADDR_LOS_FLAGS 8'h01
`define OMLSC_ADDR_RX_POWER 8'h02
`define OMLSC_ADDR_TX_DISABLE 8'h0a
`define OMLSC_ADDR_LOS_THR_HI 8'h0c
`define OMLSC_ADDR_LOS_THR_LO 8'h0d
`define OMLSC_BIT_NOT_READY 0
`define OMLSC_BIT_RESET_DONE 1
`define OMLSC_BIT_LOS_ANY 2
`define OMLSC_LOS_THR_RESET 16'h0100
`define OMLSC_TRANSMIT_DISABLE_RESET 4'h0

`endif

// file: core/omlsc_pkg.sv
// Types shared by the optical module low-speed control block.
package omlsc_pkg;

    //==========================================================
    // Synchronised host pins.
    typedef struct packed {
        logic scl;
        logic sda;
        logic select_n;
        logic reset_n;
        logic low_power;
        logic tx_disable;
    } omlsc_pins_t;

    //==========================================================
    // Measured received power of the four lanes.
    typedef logic [3:0][15:0] omlsc_lanes_t;

    //==========================================================
    // Serial slave states.
    typedef enum logic [2:0] {
        TW_IDLE,
        TW_ADDR,
        TW_ADDR_ACK,
        TW_WRITE,
        TW_WRITE_ACK,
        TW_READ,
        TW_READ_ACK
    } omlsc_tw_state_t;

endpackage : omlsc_pkg

// file: core/omlsc_sync.sv
// Two-flop synchroniser for the host pins.
module omlsc_sync
    import omlsc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins.
    input wire omlsc_pkg::omlsc_pins_t pins_async,
    output omlsc_pkg::omlsc_pins_t pins_sync
);
    import omlsc_pkg::*;

    omlsc_pins_t stage1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 6'h3c;
            pins_sync <= 6'h3c;
        end else begin
            stage1 <= pins_async;
            pins_sync <= stage1;
        end
    end

endmodule : omlsc_sync

// file: core/omlsc_rst_qual.sv
// Qualifier that passes only reset pulses longer than a minimum count.
`include "omlsc_params.svh"
module omlsc_rst_qual
#(
    parameter int MIN_CYCLES = `OMLSC_RESET_MIN_CYCLES
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Synchronised reset request and qualified reset.
    input wire logic level_n,
    output logic hold
);
    import omlsc_pkg::*;

    logic [15:0] low_count;

    //==========================================================
    // Count low cycles; a pulse shorter than the minimum is ignored.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_count <= 16'h0000;
            hold <= 1'b0;
        end else if (level_n) begin
            low_count <= 16'h0000;
            hold <= 1'b0;
        end else if (low_count >= 16'(MIN_CYCLES)) begin
            hold <= 1'b1;
        end else begin
            low_count <= low_count + 16'h0001;
        end
    end

endmodule : omlsc_rst_qual

// file: test/omlsc_chk.sv
// Port checker of the low-speed control block.
module omlsc_chk
    import omlsc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host pins.
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_select,
    input wire logic transmit_disable,
    input wire logic scl_in,
    input wire logic sda_in,
    // Outputs, and the received power input.
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic alert_n_out,
    input wire logic alert_n_oe,
    input wire logic presence_detect_n,
    input wire omlsc_pkg::omlsc_lanes_t rx_power,
    input wire logic [3:0] tx_lane_enable,
    input wire logic receive_signal_loss_alarm,
    input wire logic high_power_enable,
    input wire logic data_not_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] low_run;
    // Counts how long the reset pin has stayed low.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run <= 10'h000;
        end else if (module_reset_n) begin
            low_run <= 10'h000;
        end else if (low_run != 10'h3ff) begin
            low_run <= low_run + 10'h001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_sel_quiet: assert property (module_select_n [*6] |-> !sda_oe)
        else $error("data line driven while deselected");
    chk_alert_ready: assert property (alert_n_oe |-> !$past(data_not_ready))
        else $error("alert raised while not ready");
    chk_alert_drive: assert property (alert_n_oe |-> !alert_n_out)
        else $error("alert not driven low");
    chk_sda_drive: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    chk_presence_low: assert property (!presence_detect_n)
        else $error("presence line not low");
    chk_tx_hw: assert property (transmit_disable [*6] |-> tx_lane_enable == 4'h0)
        else $error("transmitter on while disabled");
    chk_los_clear: assert property ((rx_power == '1) [*3] |-> !receive_signal_loss_alarm)
        else $error("loss alarm with full power");
    chk_lp_limit: assert property (low_power_select [*6] |-> !high_power_enable)
        else $error("full power in low power mode");
    chk_rst_short: assert property ($rose(data_not_ready) |-> $past(low_run, 4) >= 10'h1ea)
        else $error("reset taken from a short pulse");
    chk_rst_default: assert property ($rose(data_not_ready) |-> ##[0:2]
        (tx_lane_enable == 4'h0 && !high_power_enable))
        else $error("outputs not at defaults in reset");
    cover property ($rose(alert_n_oe));
    cover property ($rose(receive_signal_loss_alarm));
    cover property ($rose(data_not_ready));
endmodule : omlsc_chk

bind omlsc_ctrl omlsc_chk u_chk (.sys_clk, .rst_n, .module_select_n, .module_reset_n,
    .low_power_select, .transmit_disable, .scl_in, .sda_in, .sda_out, .sda_oe, .alert_n_out,
    .alert_n_oe, .presence_detect_n, .rx_power, .tx_lane_enable, .receive_signal_loss_alarm,
    .high_power_enable, .data_not_ready);

// file: test/omlsc_host.sv
// Host controller model on the two-wire management bus.
`include "omlsc_params.svh"
module omlsc_host (
    // Clock.
    input wire logic sys_clk,
    // Bus and alert lines.
    input wire logic sda_oe,
    input wire logic alert_oe,
    output logic scl,
    output logic sda,
    output logic alert_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pull_low;
    // Both lines are pulled up whenever nobody holds them low.
    assign sda = !(sda_oe || pull_low);
    assign alert_n = !alert_oe;
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : cyc
    // A start condition, also used as repeated start.
    task automatic go;
        cyc(2);
        pull_low = 1'b0;
        cyc(2);
        scl = 1'b1;
        cyc(4);
        pull_low = 1'b1;
        cyc(4);
        scl = 1'b0;
    endtask : go
    task automatic halt;
        cyc(2);
        pull_low = 1'b1;
        cyc(2);
        scl = 1'b1;
        cyc(4);
        pull_low = 1'b0;
        cyc(4);
    endtask : halt
    task automatic bit_io(input logic b, output logic r);
        cyc(2);
        pull_low = !b;
        cyc(2);
        scl = 1'b1;
        cyc(4);
        r = sda;
        scl = 1'b0;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                           output logic a_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a_in, a_out);
    endtask : byte_io
    // One byte written or read at a pointer; ok when every byte the host sends is acknowledged.
    task automatic xfer(input logic rd, input logic [7:0] ptr, input logic [7:0] wd,
                        output logic [7:0] q, output logic ok);
        logic [7:0] dummy;
        logic a0;
        logic a1;
        logic a2;
        q = 8'h00;
        go();
        byte_io({`OMLSC_DEV_ADDR, 1'b0}, 1'b1, dummy, a0);
        byte_io(ptr, 1'b1, dummy, a1);
        if (rd) begin
            go();
            byte_io({`OMLSC_DEV_ADDR, 1'b1}, 1'b1, dummy, a2);
            byte_io(8'hff, 1'b1, q, dummy[0]);
        end else begin
            byte_io(wd, 1'b1, dummy, a2);
        end
        halt();
        ok = !a0 && !a1 && !a2;
    endtask : xfer
endmodule : omlsc_host

// file: test/tb.sv
// Self-checking bench of the low-speed control block.
`include "omlsc_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import omlsc_pkg::*;
    logic sys_clk, rst_n, sel_n, mrst_n, lp, txd;
    logic scl, sda, sda_out, sda_oe, alert_out, alert_oe, alert_n, prs_n;
    logic [3:0] tx_en;
    logic los, hpe, dnr, ok;
    logic [7:0] q;
    omlsc_lanes_t rx_power;
    int bad_count, n_tests, cycles;
    omlsc_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .module_select_n(sel_n),
        .module_reset_n(mrst_n), .low_power_select(lp), .transmit_disable(txd),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .alert_n_out(alert_out), .alert_n_oe(alert_oe), .presence_detect_n(prs_n),
        .rx_power(rx_power), .tx_lane_enable(tx_en), .receive_signal_loss_alarm(los),
        .high_power_enable(hpe), .data_not_ready(dnr));
    omlsc_host u_host (.sys_clk(sys_clk), .sda_oe(sda_oe), .alert_oe(alert_oe), .scl(scl),
        .sda(sda), .alert_n(alert_n));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(rd, a, d, q, ok);
    endtask : acc
    // The host waits for the alert before it trusts any status.
    task automatic wait_alert(input logic lvl);
        int k;
        k = 0;
        while (alert_n !== lvl && k < 200) begin
            u_host.cyc(1);
            k++;
        end
        check("alert", alert_n, lvl);
    endtask : wait_alert
    task automatic set_pins(input logic [4:0] v);
        {rst_n, sel_n, mrst_n, lp, txd} = v;
    endtask : set_pins
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        set_pins(5'h04);
        rx_power = '1;
        repeat (12) @(posedge sys_clk);
        #2;
        set_pins(5'h14);
        u_host.cyc(1);
        check("presence", prs_n, 8'h00);
        wait_alert(1'b0);
        check("not ready", dnr, 8'h00);
        check("high power", hpe, 8'h01);
        acc(1'b1, `OMLSC_ADDR_STATUS, 8'h00);
        check("ack", ok, 8'h01);
        check("status", q, 8'h02);
        wait_alert(1'b1);
        set_pins(5'h1c);
        acc(1'b1, `OMLSC_ADDR_STATUS, 8'h00);
        check("deselected ack", ok, 8'h00);
        check("deselected data", q, 8'hff);
        set_pins(5'h14);
        for (int i = 0; i < 4; i++) begin
            set_pins({4'ha, i[1]});
            acc(1'b0, `OMLSC_ADDR_TX_DISABLE, i[0] ? 8'h05 : 8'h00);
            u_host.cyc(8);
            check("tx lanes", tx_en, i[1] ? 4'h0 : (i[0] ? 4'ha : 4'hf));
        end
        set_pins(5'h14);
        for (int n = 0; n < 4; n++) begin
            rx_power = '1;
            rx_power[n] = {8'h10 + 8'(n), 8'h80 + 8'(n)};
            acc(1'b1, `OMLSC_ADDR_RX_POWER + 8'(2 * n), 8'h00);
            check("power high", q, 8'h10 + 8'(n));
            acc(1'b1, `OMLSC_ADDR_RX_POWER + 8'(2 * n + 1), 8'h00);
            check("power low", q, 8'h80 + 8'(n));
        end
        rx_power = '1;
        rx_power[1] = 16'h00ff;
        u_host.cyc(4);
        check("loss alarm", los, 8'h01);
        wait_alert(1'b0);
        acc(1'b1, `OMLSC_ADDR_STATUS, 8'h00);
        check("loss status", q, 8'h04);
        rx_power[1] = `OMLSC_LOS_THR_RESET;
        u_host.cyc(4);
        check("loss at threshold", los, 8'h00);
        check("alert held", alert_n, 8'h00);
        acc(1'b1, `OMLSC_ADDR_LOS_FLAGS, 8'h00);
        check("loss flags", q, 8'h02);
        wait_alert(1'b1);
        set_pins(5'h16);
        u_host.cyc(6);
        check("low power", hpe, 8'h00);
        set_pins(5'h14);
        u_host.cyc(6);
        check("full power", hpe, 8'h01);
        set_pins(5'h10);
        u_host.cyc(100);
        set_pins(5'h14);
        u_host.cyc(8);
        check("short pulse tx", tx_en, 8'h0a);
        check("short pulse ready", dnr, 8'h00);
        set_pins(5'h10);
        u_host.cyc(520);
        check("reset ready", dnr, 8'h01);
        check("reset tx", tx_en, 8'h00);
        set_pins(5'h14);
        wait_alert(1'b0);
        check("ready again", dnr, 8'h00);
        check("default tx", tx_en, 8'h0f);
        acc(1'b1, `OMLSC_ADDR_TX_DISABLE, 8'h00);
        check("default disable", q, 8'h00);
        acc(1'b1, `OMLSC_ADDR_LOS_THR_HI, 8'h00);
        check("default threshold", q, 8'h01);
        set_pins(5'h04);
        u_host.cyc(2);
        set_pins(5'h14);
        wait_alert(1'b0);
        check("power-up ready", dnr, 8'h00);
        check("power-up tx", tx_en, 8'h0f);
        tally_and_finish();
    end
endmodule : tb
